// file: include/swe_pkg.sv
// Types shared by the sleep/wake event logic
`default_nettype none
package swe_pkg;
  typedef enum logic [1:0] {
    st_work,
    st_s3,
    st_s4,
    st_s5
  } swe_state_e;
endpackage : swe_pkg
`default_nettype wire

// file: include/swe_regs.svh
// Register map, field positions and constants of the sleep/wake event logic
`ifndef SWE_REGS_SVH
`define SWE_REGS_SVH

// Byte offsets on the 32-bit bus
`define SWE_ADR_W          8
`define SWE_OFS_CTRL       8'h00
`define SWE_OFS_SLEEP      8'h04
`define SWE_OFS_WAKE_STS   8'h08

// Control register fields
`define SWE_CTRL_W         5
`define SWE_CTRL_PME_EN    0
`define SWE_CTRL_PME_DEV   1
`define SWE_CTRL_LAN_EN    2
`define SWE_CTRL_USB_EN    3
`define SWE_CTRL_RTC_EN    4
`define SWE_CTRL_RST       5'h00

// Sleep command / state field codes
`define SWE_SLP_W          2
`define SWE_SLP_WORK       2'h0
`define SWE_SLP_S3         2'h1
`define SWE_SLP_S4         2'h2
`define SWE_SLP_S5         2'h3

// Wake source bit positions
`define SWE_NSRC           9
`define SWE_SRC_PWRBTN     0
`define SWE_SRC_SMBALERT   1
`define SWE_SRC_PCIEWAKE   2
`define SWE_SRC_WDTBTN     3
`define SWE_SRC_GENWAKE    4
`define SWE_SRC_PME        5
`define SWE_SRC_LAN        6
`define SWE_SRC_USB        7
`define SWE_SRC_RTC        8
`define SWE_STS_RST        9'h000
// Sources that wake from any sleep state with no enable
`define SWE_UNCOND_MASK    9'h00F
// Pins asserted at low level
`define SWE_ACT_LOW_MASK   9'h0F7

`endif

// file: rtl/swe_sync.sv
// Two-flop synchroniser with polarity fix-up and assertion-edge detect
`default_nettype none
module swe_sync #(
  parameter bit ACT_LOW = 1'b1
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Pin and result
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Flops reset to the pin's idle level so reset makes no false edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q <= ACT_LOW;
      sync_q <= ACT_LOW;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= level_o;
    end
  end

  assign level_o = ACT_LOW ? ~sync_q : sync_q;
  assign rise_o  = level_o & ~prev_q;
endmodule : swe_sync
`default_nettype wire

// file: rtl/swe_wake_logic.sv
// Sleep-state tracking and wake-event qualification with Wishbone registers
//
// Our own choices: register access over Wishbone and the register addresses.
`include "swe_regs.svh"
`default_nettype none
module swe_wake_logic
  import swe_pkg::*;
#(
  parameter bit STRAP_TIED = 1'b1
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Wake source pins
  input  wire logic        pwr_btn_n_i,
  input  wire logic        smb_alert_n_i,
  input  wire logic        pcie_wake_n_i,
  input  wire logic        wdt_pwrbtn_i,
  input  wire logic        gen_wake_n_i,
  input  wire logic        pme_n_i,
  input  wire logic        lan_wake_n_i,
  input  wire logic        usb_wake_n_i,
  input  wire logic        rtc_alarm_i,
  input  wire logic        usb_sby_pwr_i,
  // Sleep state and resume outputs
  output logic             slp_s3_n_o,
  output logic             slp_s4_n_o,
  output logic             slp_s5_n_o,
  output logic             resume_o,
  // Capability strap, open drain
  output logic             capability_strap_output_o,
  output logic             capability_strap_output_oe_o
);

  localparam logic [`SWE_NSRC-1:0] ACT_LOW_MASK = `SWE_ACT_LOW_MASK;
  localparam logic [`SWE_NSRC-1:0] UNCOND_MASK  = `SWE_UNCOND_MASK;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`SWE_NSRC-1:0] pin_raw;
  logic [`SWE_NSRC-1:0] src_rise;
  logic                 usb_pwr_ok;

  assign pin_raw[`SWE_SRC_PWRBTN]   = pwr_btn_n_i;
  assign pin_raw[`SWE_SRC_SMBALERT] = smb_alert_n_i;
  assign pin_raw[`SWE_SRC_PCIEWAKE] = pcie_wake_n_i;
  assign pin_raw[`SWE_SRC_WDTBTN]   = wdt_pwrbtn_i;
  assign pin_raw[`SWE_SRC_GENWAKE]  = gen_wake_n_i;
  assign pin_raw[`SWE_SRC_PME]      = pme_n_i;
  assign pin_raw[`SWE_SRC_LAN]      = lan_wake_n_i;
  assign pin_raw[`SWE_SRC_USB]      = usb_wake_n_i;
  assign pin_raw[`SWE_SRC_RTC]      = rtc_alarm_i;

  for (genvar i = 0; i < `SWE_NSRC; i++) begin : g_sync
    swe_sync #(
      .ACT_LOW (ACT_LOW_MASK[i])
    ) u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .pin_i     (pin_raw[i]),
      .level_o   (),
      .rise_o    (src_rise[i])
    );
  end

  swe_sync #(
    .ACT_LOW (1'b0)
  ) u_usb_pwr (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (usb_sby_pwr_i),
    .level_o   (usb_pwr_ok),
    .rise_o    ()
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake and decode

  logic rd_cap;
  logic wr_stb;

  swe_wb_slave u_wb (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_ack_o  (wb_ack_o),
    .rd_cap_o  (rd_cap),
    .wr_stb_o  (wr_stb)
  );

  logic                   hit_ctrl;
  logic                   hit_sleep;
  logic                   hit_sts;
  logic                   wr_ctrl;
  logic                   wr_sleep;
  logic [`SWE_NSRC-1:0]   sts_clr;

  assign hit_ctrl  = (wb_adr_i == `SWE_OFS_CTRL);
  assign hit_sleep = (wb_adr_i == `SWE_OFS_SLEEP);
  assign hit_sts   = (wb_adr_i == `SWE_OFS_WAKE_STS);
  assign wr_ctrl   = wr_stb & hit_ctrl & wb_sel_i[0];
  assign wr_sleep  = wr_stb & hit_sleep & wb_sel_i[0];
  // Write one to clear, byte lanes honoured
  assign sts_clr   = (wr_stb & hit_sts)
                   ? (wb_dat_i[`SWE_NSRC-1:0]
                      & {wb_sel_i[1], {(`SWE_NSRC-1){wb_sel_i[0]}}})
                   : '0;

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [`SWE_CTRL_W-1:0] ctrl_q;
  logic [`SWE_NSRC-1:0]   wake_sts_q;
  logic [31:0]            rdata_q;
  logic [31:0]            rd_mux;
  logic [`SWE_SLP_W-1:0]  slp_code;

  wire pme_en  = ctrl_q[`SWE_CTRL_PME_EN];
  wire pme_dev = ctrl_q[`SWE_CTRL_PME_DEV];
  wire lan_en  = ctrl_q[`SWE_CTRL_LAN_EN];
  wire usb_en  = ctrl_q[`SWE_CTRL_USB_EN];
  wire rtc_en  = ctrl_q[`SWE_CTRL_RTC_EN];

  swe_state_e state_q;
  swe_state_e state_d;

  assign slp_code = (state_q == st_s3) ? `SWE_SLP_S3
                  : (state_q == st_s4) ? `SWE_SLP_S4
                  : (state_q == st_s5) ? `SWE_SLP_S5
                  : `SWE_SLP_WORK;

  // Unmapped offsets read as zero and still get ack
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[`SWE_CTRL_W-1:0] = ctrl_q;
    end else if (hit_sleep) begin
      rd_mux[`SWE_SLP_W-1:0] = slp_code;
    end else if (hit_sts) begin
      rd_mux[`SWE_NSRC-1:0] = wake_sts_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_cap) begin
      rdata_q <= rd_mux;
    end
  end

  assign wb_dat_o = rdata_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_q <= `SWE_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wb_dat_i[`SWE_CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake qualification

  logic                 in_sleep;
  logic [`SWE_NSRC-1:0] allow;
  logic [`SWE_NSRC-1:0] qual;
  logic                 wake;

  assign in_sleep = (state_q != st_work);

  assign allow[`SWE_SRC_PWRBTN]   = in_sleep;
  assign allow[`SWE_SRC_SMBALERT] = in_sleep;
  assign allow[`SWE_SRC_PCIEWAKE] = in_sleep;
  assign allow[`SWE_SRC_WDTBTN]   = in_sleep;
  assign allow[`SWE_SRC_GENWAKE]  = (state_q == st_s3);
  assign allow[`SWE_SRC_PME]      = in_sleep & (pme_en | pme_dev);
  assign allow[`SWE_SRC_LAN]      = in_sleep & lan_en;
  // USB needs S3, standby power, enable
  assign allow[`SWE_SRC_USB]      = (state_q == st_s3) & usb_en & usb_pwr_ok;
  assign allow[`SWE_SRC_RTC]      = (state_q == st_s5) & rtc_en;

  assign qual = src_rise & allow;
  assign wake = |qual;

  // Sticky source record, a new wake beats a clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wake_sts_q <= `SWE_STS_RST;
    end else begin
      wake_sts_q <= (wake_sts_q & ~sts_clr) | qual;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep state machine

  // Sleep entered by command, left only by a wake
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_work: begin
        if (wr_sleep) begin
          case (wb_dat_i[`SWE_SLP_W-1:0])
            `SWE_SLP_S3: state_d = st_s3;
            `SWE_SLP_S4: state_d = st_s4;
            `SWE_SLP_S5: state_d = st_s5;
            default:     state_d = st_work;
          endcase
        end
      end
      st_s3, st_s4, st_s5: begin
        if (wake) begin
          state_d = st_work;
        end
      end
      default: state_d = st_work;
    endcase
  end

  logic resume_q;
  logic s3_n_q;
  logic s4_n_q;
  logic s5_n_q;

  // Power-up lands in soft-off: the carrier must wake the module first
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q  <= st_s5;
      resume_q <= 1'b0;
      s3_n_q   <= 1'b0;
      s4_n_q   <= 1'b0;
      s5_n_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      resume_q <= in_sleep & wake;
      s3_n_q   <= (state_d == st_work);
      s4_n_q   <= (state_d == st_work) | (state_d == st_s3);
      s5_n_q   <= (state_d != st_s5);
    end
  end

  assign resume_o   = resume_q;
  assign slp_s3_n_o = s3_n_q;
  assign slp_s4_n_o = s4_n_q;
  assign slp_s5_n_o = s5_n_q;

  // Strap is grounded or floats, never driven high
  assign capability_strap_output_o    = 1'b0;
  assign capability_strap_output_oe_o = STRAP_TIED;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_work_no_wake: assert property (
    state_q == st_work |=> !resume_o)
    else $error("resume pulse while working");

  a_uncond_wake: assert property (
    in_sleep && |(src_rise & UNCOND_MASK) |=> resume_o && state_q == st_work)
    else $error("unconditional source did not wake");

  a_gen_s3_only: assert property (
    state_q == st_s3 && src_rise[`SWE_SRC_GENWAKE] |=> resume_o)
    else $error("general wake ignored in S3");

  a_gen_not_deep: assert property (
    (state_q == st_s4 || state_q == st_s5)
    && src_rise == (1 << `SWE_SRC_GENWAKE) |=> !resume_o)
    else $error("general wake woke from S4 or S5");

  a_rtc_gate: assert property (
    src_rise == (1 << `SWE_SRC_RTC) && in_sleep
    |=> resume_o == $past(state_q == st_s5 && rtc_en))
    else $error("RTC alarm gating wrong");

  a_pme_gate: assert property (
    src_rise == (1 << `SWE_SRC_PME) && in_sleep
    |=> resume_o == $past(pme_en || pme_dev))
    else $error("PME gating wrong");

  a_lan_gate: assert property (
    src_rise == (1 << `SWE_SRC_LAN) && in_sleep
    |=> resume_o == $past(lan_en))
    else $error("LAN gating wrong");

  a_usb_gate: assert property (
    src_rise == (1 << `SWE_SRC_USB) && in_sleep
    |=> resume_o == $past(state_q == st_s3 && usb_en && usb_pwr_ok))
    else $error("USB gating wrong");

  a_one_resume: assert property (
    resume_o |=> !resume_o [*3])
    else $error("more than one resume pulse");

  a_stay_asleep: assert property (
    in_sleep && !wake |=> state_q == $past(state_q))
    else $error("left sleep without wake");

  a_sleep_pins: assert property (
    !slp_s5_n_o == (state_q == st_s5) && slp_s3_n_o == !in_sleep)
    else $error("sleep indication mismatch");

  a_strap_low: assert property (
    !capability_strap_output_o && $stable(capability_strap_output_oe_o))
    else $error("capability strap not static low");

  c_wake_s3: cover property (state_q == st_s3 ##1 resume_o);
  c_rtc_s5: cover property (state_q == st_s5 && qual[`SWE_SRC_RTC]);
  c_enter_s4: cover property (state_q == st_work ##1 state_q == st_s4);
  c_sts_clr: cover property (|sts_clr && |wake_sts_q);

endmodule : swe_wake_logic
`default_nettype wire

// file: rtl/swe_wb_slave.sv
// Classic Wishbone handshake: registered ack, read capture, write strobe
`default_nettype none
module swe_wb_slave (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Bus handshake
  input  wire logic wb_cyc_i,
  input  wire logic wb_stb_i,
  input  wire logic wb_we_i,
  output logic      wb_ack_o,
  // Towards the register file
  output logic      rd_cap_o,
  output logic      wr_stb_o
);
  logic req;
  logic ack_q;

  assign req      = wb_cyc_i & wb_stb_i;
  assign wb_ack_o = ack_q;
  // Read data is latched on the same edge that raises ack so it comes from a flop
  assign rd_cap_o = req & ~ack_q & ~wb_we_i;
  // Write lands on the same edge the master samples ack
  assign wr_stb_o = req & ack_q & wb_we_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end
endmodule : swe_wb_slave
`default_nettype wire

// file: verif/swe_carrier.sv
// Carrier-board wake devices driving the wake pins with their polarity
`include "swe_regs.svh"
`default_nettype none
module swe_carrier (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Bench commands
  input  wire logic [8:0] req_i,
  input  wire logic       sby_i,
  // Wake pins
  output logic            pwr_btn_n_o,
  output logic            smb_alert_n_o,
  output logic            pcie_wake_n_o,
  output logic            wdt_pwrbtn_o,
  output logic            gen_wake_n_o,
  output logic            pme_n_o,
  output logic            lan_wake_n_o,
  output logic            usb_wake_n_o,
  output logic            rtc_alarm_o,
  output logic            usb_sby_pwr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] act_q;
  logic [1:0] hold_q;
  logic [8:0] pin_w;
  // Hold a request four cycles so the two-flop sync cannot miss it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      act_q  <= 9'h000;
      hold_q <= 2'h0;
    end else if (req_i != 9'h000) begin
      act_q  <= req_i;
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else begin
      act_q  <= 9'h000;
    end
  end
  assign pin_w = (act_q & {9{~rst_i}}) ^ `SWE_ACT_LOW_MASK;
  assign usb_sby_pwr_o = sby_i;
  assign pwr_btn_n_o   = pin_w[`SWE_SRC_PWRBTN];
  assign smb_alert_n_o = pin_w[`SWE_SRC_SMBALERT];
  assign pcie_wake_n_o = pin_w[`SWE_SRC_PCIEWAKE];
  assign wdt_pwrbtn_o  = pin_w[`SWE_SRC_WDTBTN];
  assign gen_wake_n_o  = pin_w[`SWE_SRC_GENWAKE];
  assign pme_n_o       = pin_w[`SWE_SRC_PME];
  assign lan_wake_n_o  = pin_w[`SWE_SRC_LAN];
  assign usb_wake_n_o  = pin_w[`SWE_SRC_USB];
  assign rtc_alarm_o   = pin_w[`SWE_SRC_RTC];
endmodule : swe_carrier
`default_nettype wire

// file: verif/swe_wake_logic_tb.sv
// Self-checking bench for the sleep/wake event logic
`include "swe_regs.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module swe_wake_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0;
  logic        rst_i;
  logic        cyc, stb, we, sby;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [8:0]  req;
  wire  [31:0] dat_o;
  wire         ack, pb, sa, pw, wd, gw, pm, ln, ub, rt, sp;
  wire         s3_n, s4_n, s5_n, resume, strap, strap_oe;
  integer      fails, n_tests, seed;
  logic [31:0] r;
  int          np;

  always #2 sys_clk_i = ~sys_clk_i;

  swe_carrier swe_carrier_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .req_i(req), .sby_i(sby), .pwr_btn_n_o(pb), .smb_alert_n_o(sa),
    .pcie_wake_n_o(pw), .wdt_pwrbtn_o(wd), .gen_wake_n_o(gw),
    .pme_n_o(pm), .lan_wake_n_o(ln), .usb_wake_n_o(ub),
    .rtc_alarm_o(rt), .usb_sby_pwr_o(sp));

  swe_wake_logic swe_wake_logic_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pwr_btn_n_i(pb), .smb_alert_n_i(sa), .pcie_wake_n_i(pw),
    .wdt_pwrbtn_i(wd), .gen_wake_n_i(gw), .pme_n_i(pm),
    .lan_wake_n_i(ln), .usb_wake_n_i(ub), .rtc_alarm_i(rt),
    .usb_sby_pwr_i(sp), .slp_s3_n_o(s3_n), .slp_s4_n_o(s4_n),
    .slp_s5_n_o(s5_n), .resume_o(resume),
    .capability_strap_output_o(strap),
    .capability_strap_output_oe_o(strap_oe));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] exp_slp(input logic [1:0] code);
    case (code)
      2'h0: exp_slp = 3'h7;
      2'h1: exp_slp = 3'h3;
      2'h2: exp_slp = 3'h1;
      default: exp_slp = 3'h0;
    endcase
  endfunction : exp_slp

  function automatic logic qual(input logic [1:0] st, input int src,
                                input logic [4:0] c, input logic sb);
    case (src)
      4: qual = (st == 2'h1);
      5: qual = c[0] | c[1];
      6: qual = c[2];
      7: qual = (st == 2'h1) & c[3] & sb;
      8: qual = (st == 2'h3) & c[4];
      default: qual = 1'b1;
    endcase
  endfunction : qual

  // One classic cycle; only the watchdog ends a wait for ack
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge sys_clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  // Pulse wake sources and count resume pulses that follow
  task automatic fire(input logic [8:0] m, output int cnt);
    @(posedge sys_clk_i);
    req <= m;
    @(posedge sys_clk_i);
    req <= 9'h000;
    cnt = 0;
    repeat (12) begin
      @(posedge sys_clk_i);
      if (resume === 1'b1) cnt++;
    end
  endtask : fire

  task automatic trial(input logic [1:0] code, input int src);
    logic [4:0] c;
    logic       q;
    c = 5'($random(seed));
    sby <= 1'($random(seed));
    bus(1'b1, `SWE_OFS_WAKE_STS, 32'h1FF, r);
    bus(1'b1, `SWE_OFS_CTRL, {27'h0, c}, r);
    bus(1'b1, `SWE_OFS_SLEEP, {30'h0, code}, r);
    @(posedge sys_clk_i);
    `CHK("sleep pins", exp_slp(code), {s3_n, s4_n, s5_n})
    q = qual(code, src, c, sby);
    fire(9'h001 << src, np);
    `CHK("resume", 32'(q), np)
    bus(1'b0, `SWE_OFS_WAKE_STS, 32'h0, r);
    `CHK("status", q ? (32'h1 << src) : 32'h0, r)
    bus(1'b0, `SWE_OFS_SLEEP, 32'h0, r);
    `CHK("state", q ? 32'h0 : {30'h0, code}, r)
    if (!q) begin
      fire(9'h001, np);
      `CHK("button wake", 1, np)
    end
    bus(1'b1, `SWE_OFS_WAKE_STS, 32'h1FF, r);
    fire(9'h001 << src, np);
    `CHK("working resume", 0, np)
    bus(1'b0, `SWE_OFS_WAKE_STS, 32'h0, r);
    `CHK("working status", 32'h0, r)
  endtask : trial

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fails++;
    finish_test();
  end

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, sby} = 4'h0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    req = 9'h000;
    fails = 0;
    n_tests = 0;
    seed = 81;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    bus(1'b0, `SWE_OFS_SLEEP, 32'h0, r);
    `CHK("reset state", 32'h3, r)
    `CHK("reset pins", 3'h0, {s3_n, s4_n, s5_n})
    `CHK("strap", 2'h1, {strap, strap_oe})
    bus(1'b0, 8'h0C, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    fire(9'h001, np);
    `CHK("first wake", 1, np)
    $display("reset test done");
    for (int p = 0; p < 2; p++) begin
      for (int s = 1; s <= 3; s++) begin
        for (int i = 0; i < 9; i++) trial(2'(s), i);
      end
      $display("source sweep %0d done", p);
    end
    bus(1'b1, `SWE_OFS_WAKE_STS, 32'h1FF, r);
    bus(1'b1, `SWE_OFS_SLEEP, 32'h1, r);
    // A sleep command while already asleep must not move the state
    bus(1'b1, `SWE_OFS_SLEEP, 32'h3, r);
    bus(1'b0, `SWE_OFS_SLEEP, 32'h0, r);
    `CHK("sleep refused", 32'h1, r)
    fire(9'h00B, np);
    `CHK("joint resume", 1, np)
    bus(1'b0, `SWE_OFS_WAKE_STS, 32'h0, r);
    `CHK("joint status", 32'h00B, r)
    $display("joint wake test done");
    finish_test();
  end
endmodule : swe_wake_logic_tb
`default_nettype wire
